/* hw/bbx_pkg.sv */
// Package: constants, opcodes and register map of the byte/bit executor.
// Assumes an APB master on a 32-bit data bus and a single clock domain.
package bbx_pkg;

  // Register byte offsets
  localparam logic [7:0] BBX_OFS_INSTR = 8'h00;
  localparam logic [7:0] BBX_OFS_WREG = 8'h04;
  localparam logic [7:0] BBX_OFS_STATUS = 8'h08;
  localparam logic [7:0] BBX_OFS_FADDR = 8'h0C;
  localparam logic [7:0] BBX_OFS_FDATA = 8'h10;
  localparam logic [7:0] BBX_OFS_CYCLES = 8'h14;

  // Status field positions
  localparam int BBX_ST_CARRY = 0;
  localparam int BBX_ST_NIBBLE = 1;
  localparam int BBX_ST_ZERO = 2;
  localparam int BBX_ST_SKIP = 3;
  localparam int BBX_ST_BAD = 4;

  // Instruction field positions
  localparam int BBX_IW_CLASS_HI = 13;
  localparam int BBX_IW_CLASS_LO = 12;
  localparam int BBX_IW_DEST = 7;
  localparam int BBX_IW_BIT_HI = 9;
  localparam int BBX_IW_BIT_LO = 7;

  // Reset values
  localparam logic [7:0] BBX_RST_WREG = 8'h00;
  localparam logic [2:0] BBX_RST_FLAGS = 3'h0;
  localparam logic [6:0] BBX_RST_FADDR = 7'h00;
  localparam logic [13:0] BBX_RST_INSTR = 14'h0000;
  localparam logic [15:0] BBX_RST_CYCLES = 16'h0000;

  // Opcode encodings
  localparam logic [1:0] BBX_CLS_BYTE = 2'h0;
  localparam logic [1:0] BBX_CLS_BIT = 2'h1;
  localparam logic [1:0] BBX_CLS_LIT = 2'h3;
  localparam logic [3:0] BBX_SUB_FSUM = 4'h7;
  localparam logic [3:0] BBX_SUB_FMASK = 4'h5;
  localparam logic [3:0] BBX_SUB_FCLR = 4'h1;
  localparam logic [1:0] BBX_SUB_BCLR = 2'h0;
  localparam logic [1:0] BBX_SUB_BSET = 2'h1;
  localparam logic [1:0] BBX_SUB_SKZ = 2'h2;
  localparam logic [1:0] BBX_SUB_SKO = 2'h3;
  localparam logic [2:0] BBX_SUB_LSUM = 3'h7;
  localparam logic [3:0] BBX_SUB_LMASK = 4'h9;

  typedef enum logic [3:0] {
    BBX_OP_IDLE = 4'h0,
    BBX_OP_FSUM = 4'h1,
    BBX_OP_FMASK = 4'h2,
    BBX_OP_FCLR = 4'h3,
    BBX_OP_BCLR = 4'h4,
    BBX_OP_BSET = 4'h5,
    BBX_OP_SKZ = 4'h6,
    BBX_OP_SKO = 4'h7,
    BBX_OP_LSUM = 4'h8,
    BBX_OP_LMASK = 4'h9,
    BBX_OP_BAD = 4'hA
  } bbx_op_t;

  typedef enum logic [0:0] {
    BBX_ST_IDLE = 1'b0,
    BBX_ST_EXEC = 1'b1
  } bbx_state_t;

endpackage

/* hw/bbx_alu.sv */
// Combinational datapath: result, flags, destination and skip decision.
// Assumes operands are stable for the execute cycle of the caller.
`timescale 1ns/1ps
module bbx_alu import bbx_pkg::*; (
  input wire bbx_op_t op,
  input wire logic [7:0] wreg,
  input wire logic [7:0] fval,
  input wire logic [7:0] lit,
  input wire logic [2:0] bitsel,
  input wire logic dest,
  input wire logic [2:0] flags_in,
  output logic [7:0] result,
  output logic [2:0] flags_out,
  output logic write_w,
  output logic write_f,
  output logic skip
);

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  logic [7:0] bit_mask;

  always_comb begin
    addend = (op == BBX_OP_LSUM) ? lit : fval;
    sum = {1'b0, wreg} + {1'b0, addend};
    low_sum = {1'b0, wreg[3:0]} + {1'b0, addend[3:0]};
    bit_mask = 8'h01 << bitsel;
    result = 8'h00;
    flags_out = flags_in;
    write_w = 1'b0;
    write_f = 1'b0;
    skip = 1'b0;
    case (op)
      BBX_OP_LSUM: begin
        result = sum[7:0];
        write_w = 1'b1;
      end
      BBX_OP_FSUM: begin
        result = sum[7:0];
        write_w = ~dest;
        write_f = dest;
      end
      BBX_OP_FMASK: begin
        result = wreg & fval;
        write_w = ~dest;
        write_f = dest;
      end
      BBX_OP_LMASK: begin
        result = wreg & lit;
        write_w = 1'b1;
      end
      BBX_OP_FCLR: begin
        result = 8'h00;
        write_f = 1'b1;
      end
      BBX_OP_BCLR: begin
        result = fval & ~bit_mask;
        write_f = 1'b1;
      end
      BBX_OP_BSET: begin
        result = fval | bit_mask;
        write_f = 1'b1;
      end
      BBX_OP_SKZ: begin
        skip = ~|(fval & bit_mask);
      end
      BBX_OP_SKO: begin
        skip = |(fval & bit_mask);
      end
      default: begin
        result = 8'h00;
      end
    endcase
    if (op == BBX_OP_LSUM || op == BBX_OP_FSUM) begin
      flags_out[BBX_ST_CARRY] = sum[8];
      flags_out[BBX_ST_NIBBLE] = low_sum[4];
    end
    if (op == BBX_OP_LSUM || op == BBX_OP_FSUM ||
        op == BBX_OP_FMASK || op == BBX_OP_LMASK) begin
      flags_out[BBX_ST_ZERO] = (result == 8'h00);
    end
    if (op == BBX_OP_FCLR) begin
      flags_out[BBX_ST_ZERO] = 1'b1;
    end
  end

endmodule

/* hw/bbx_exec.sv */
// Byte and bit instruction executor with its own file of 128 bytes.
// Assumes an APB master on pclk; instructions arrive as register writes.
//
// Functional notes
// - Literal sum adds immediate to working register, updates C, DC, Z.
// - File sum adds file register to working register, updates C, DC, Z.
// - Destination bit 0 sends result to working register, 1 to file.
// - File mask ANDs working and file register, updates only Z.
// - Literal mask ANDs immediate into working register, updates only Z.
// - Bit clear zeroes one bit of a file register, flags untouched.
// - Bit set forces one bit of a file register high, flags untouched.
// - Skip-on-zero test discards next instruction when bit is zero.
// - Skip-on-one test discards next instruction when bit is one.
// - File clear writes zero to file register and sets Z.
// - A successful test costs two cycles, the second an idle cycle.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module bbx_exec import bbx_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic skip_request
);

  // File register storage
  logic [7:0] file_mem [0:127];

  bbx_state_t state;
  bbx_state_t next_state;
  logic [13:0] instr;
  logic [13:0] next_instr;
  logic [7:0] wreg;
  logic [7:0] next_wreg;
  logic [2:0] flags;
  logic [2:0] next_flags;
  logic skip_pend;
  logic next_skip_pend;
  logic bad_op;
  logic next_bad_op;
  logic [6:0] faddr;
  logic [6:0] next_faddr;
  logic [15:0] cycles;
  logic [15:0] next_cycles;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_skip_request;

  logic mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;

  logic xfer;
  logic wr_xfer;
  logic addr_ok;
  logic [1:0] iw_class;
  logic [3:0] iw_sub;
  bbx_op_t op;
  logic [6:0] op_faddr;
  logic [7:0] alu_result;
  logic [2:0] alu_flags;
  logic alu_write_w;
  logic alu_write_f;
  logic alu_skip;
  logic wr_go;
  logic wr_instr;
  logic wr_wreg;
  logic wr_status;
  logic wr_faddr;
  logic wr_fdata;
  logic executing;
  logic bad_clear;
  logic [7:0] op_lit;
  logic [2:0] op_bitsel;
  logic op_dest;
  logic [31:0] rd_value;

  assign xfer = psel & penable & pready;
  assign wr_xfer = xfer & pwrite;
  assign iw_class = instr[BBX_IW_CLASS_HI:BBX_IW_CLASS_LO];
  assign iw_sub = instr[11:8];
  assign op_faddr = instr[6:0];

  // Operand fields of the held instruction
  assign op_lit = instr[7:0];
  assign op_bitsel = instr[BBX_IW_BIT_HI:BBX_IW_BIT_LO];
  assign op_dest = instr[BBX_IW_DEST];

  // Write strobes; the bus only completes while idle
  assign wr_go = wr_xfer & (state == BBX_ST_IDLE);
  assign wr_instr = wr_go & (paddr == BBX_OFS_INSTR);
  assign wr_wreg = wr_go & (paddr == BBX_OFS_WREG);
  assign wr_status = wr_go & (paddr == BBX_OFS_STATUS);
  assign wr_faddr = wr_go & (paddr == BBX_OFS_FADDR);
  assign wr_fdata = wr_go & (paddr == BBX_OFS_FDATA);
  assign executing = (state == BBX_ST_EXEC);
  assign bad_clear = wr_status & pwdata[BBX_ST_BAD];

  // Opcode decode
  always_comb begin
    op = BBX_OP_BAD;
    case (iw_class)
      BBX_CLS_BYTE: begin
        if (iw_sub == BBX_SUB_FSUM) begin
          op = BBX_OP_FSUM;
        end else if (iw_sub == BBX_SUB_FMASK) begin
          op = BBX_OP_FMASK;
        end else if (iw_sub == BBX_SUB_FCLR && instr[BBX_IW_DEST]) begin
          op = BBX_OP_FCLR;
        end else if (iw_sub == 4'h0 && instr[7] == 1'b0 &&
                     instr[4:0] == 5'h00) begin
          op = BBX_OP_IDLE;
        end else begin
          op = BBX_OP_BAD;
        end
      end
      BBX_CLS_BIT: begin
        case (iw_sub[3:2])
          BBX_SUB_BCLR: op = BBX_OP_BCLR;
          BBX_SUB_BSET: op = BBX_OP_BSET;
          BBX_SUB_SKZ: op = BBX_OP_SKZ;
          BBX_SUB_SKO: op = BBX_OP_SKO;
          default: op = BBX_OP_BAD;
        endcase
      end
      BBX_CLS_LIT: begin
        if (iw_sub[3:1] == BBX_SUB_LSUM) begin
          op = BBX_OP_LSUM;
        end else if (iw_sub == BBX_SUB_LMASK) begin
          op = BBX_OP_LMASK;
        end else begin
          op = BBX_OP_BAD;
        end
      end
      default: op = BBX_OP_BAD;
    endcase
  end

  bbx_alu bbx_alu_i (
    .op(op),
    .wreg(wreg),
    .fval(file_mem[op_faddr]),
    .lit(op_lit),
    .bitsel(op_bitsel),
    .dest(op_dest),
    .flags_in(flags),
    .result(alu_result),
    .flags_out(alu_flags),
    .write_w(alu_write_w),
    .write_f(alu_write_f),
    .skip(alu_skip)
  );

  // Address decode
  always_comb begin
    case (paddr)
      BBX_OFS_INSTR, BBX_OFS_WREG, BBX_OFS_STATUS,
      BBX_OFS_FADDR, BBX_OFS_FDATA, BBX_OFS_CYCLES: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Read mux over the register map
  always_comb begin
    rd_value = 32'h0000_0000;
    case (paddr)
      BBX_OFS_INSTR: rd_value = {18'h00000, instr};
      BBX_OFS_WREG: rd_value = {24'h000000, wreg};
      BBX_OFS_STATUS: begin
        rd_value = {27'h0000000, bad_op, skip_pend, flags};
      end
      BBX_OFS_FADDR: rd_value = {25'h0000000, faddr};
      BBX_OFS_FDATA: rd_value = {24'h000000, file_mem[faddr]};
      BBX_OFS_CYCLES: rd_value = {16'h0000, cycles};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // Bus answer: one wait state, held off while executing
  always_comb begin
    next_pready = psel & penable & ~pready & (state == BBX_ST_IDLE);
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (next_pready) begin
      next_pslverr = ~addr_ok;
      next_prdata = rd_value;
    end
  end

  // Bus answer registers, zero outside the answer cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Sequencer: issue, discard and cycle count
  always_comb begin
    next_state = state;
    next_instr = instr;
    next_cycles = cycles;
    case (state)
      BBX_ST_IDLE: begin
        if (wr_instr) begin
          next_instr = pwdata[13:0];
          if (skip_pend) begin
            next_cycles = cycles + 16'h0001;
          end else begin
            next_state = BBX_ST_EXEC;
          end
        end
      end
      BBX_ST_EXEC: begin
        next_state = BBX_ST_IDLE;
        next_cycles = cycles + 16'h0001;
      end
      default: begin
        next_state = BBX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= BBX_ST_IDLE;
      instr <= BBX_RST_INSTR;
      cycles <= BBX_RST_CYCLES;
    end else begin
      state <= next_state;
      instr <= next_instr;
      cycles <= next_cycles;
    end
  end

  // Skip pending and sticky bad-opcode flag
  always_comb begin
    next_skip_pend = skip_pend;
    next_bad_op = bad_op;
    if (wr_instr && skip_pend) begin
      next_skip_pend = 1'b0;
    end
    if (executing && alu_skip) begin
      next_skip_pend = 1'b1;
    end
    // Clear first so that a set wins
    if (bad_clear) begin
      next_bad_op = 1'b0;
    end
    if (executing && op == BBX_OP_BAD) begin
      next_bad_op = 1'b1;
    end
    next_skip_request = next_skip_pend;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_pend <= 1'b0;
      bad_op <= 1'b0;
      skip_request <= 1'b0;
    end else begin
      skip_pend <= next_skip_pend;
      bad_op <= next_bad_op;
      skip_request <= next_skip_request;
    end
  end

  // Working register, flags and file pointer
  always_comb begin
    next_wreg = wreg;
    next_flags = flags;
    next_faddr = faddr;
    if (executing) begin
      next_flags = alu_flags;
      if (alu_write_w) begin
        next_wreg = alu_result;
      end
    end else begin
      if (wr_wreg) begin
        next_wreg = pwdata[7:0];
      end
      if (wr_status) begin
        next_flags = pwdata[BBX_ST_ZERO:BBX_ST_CARRY];
      end
      if (wr_faddr) begin
        next_faddr = pwdata[6:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg <= BBX_RST_WREG;
      flags <= BBX_RST_FLAGS;
      faddr <= BBX_RST_FADDR;
    end else begin
      wreg <= next_wreg;
      flags <= next_flags;
      faddr <= next_faddr;
    end
  end

  // File write port: executed result or bus data
  always_comb begin
    mem_we = 1'b0;
    mem_addr = faddr;
    mem_wdata = pwdata[7:0];
    if (executing) begin
      if (alu_write_f) begin
        mem_we = 1'b1;
        mem_addr = op_faddr;
        mem_wdata = alu_result;
      end
    end else if (wr_fdata) begin
      mem_we = 1'b1;
    end
  end

  // Data store has no reset
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      file_mem[mem_addr] <= mem_wdata;
    end
  end

endmodule

/* bench/bbx_exec_assertions.sv */
// Checker: port-level assertions on the byte/bit executor.
// Assumes one pclk domain and presetn asynchronous, active low.
`timescale 1ns/1ps
module bbx_exec_assertions import bbx_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic skip_request
);
  logic [15:0] cnt, next_cnt;
  logic zexp, next_zexp, wz, next_wz;
  logic acc, rd, wi, ex, bitop, clr, lmz, skw;
  assign acc = psel && penable && pready;
  assign rd = acc && !pwrite;
  assign wi = acc && pwrite && paddr == BBX_OFS_INSTR;
  assign ex = wi && !skip_request;
  assign bitop = pwdata[13:12] == BBX_CLS_BIT;
  assign clr = pwdata[13:7] == 7'h03;
  assign lmz = pwdata[13:8] == 6'h39 && pwdata[7:0] == 8'h00;
  assign skw = wi && bitop && pwdata[11];
  // Tracks zero flag and zero W known from executed instructions
  always_comb begin
    next_cnt = wi ? cnt + 16'h0001 : cnt;
    next_zexp = zexp;
    next_wz = wz;
    if (ex && !bitop) begin
      next_zexp = clr || lmz;
      next_wz = lmz || (clr && wz);
    end
    if (acc && pwrite && paddr == BBX_OFS_STATUS) next_zexp = 1'b0;
    if (acc && pwrite && paddr == BBX_OFS_WREG) next_wz = 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      zexp <= 1'b0;
      wz <= 1'b0;
    end else begin
      cnt <= next_cnt;
      zexp <= next_zexp;
      wz <= next_wz;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_skip_rise_cause: assert property (
    $rose(skip_request) |-> $past(skw) || $past(skw, 2))
    else $error("skip raised without a bit test");
  a_skip_clears: assert property (
    skip_request && wi |-> ##[1:2] !skip_request)
    else $error("skip not cleared by next instruction");
  a_skip_fall_cause: assert property (
    $fell(skip_request) |-> $past(wi) || $past(wi, 2))
    else $error("skip dropped without instruction");
  a_skip_status_bit: assert property (
    rd && paddr == BBX_OFS_STATUS |-> prdata[BBX_ST_SKIP] == skip_request)
    else $error("status skip bit differs from port");
  a_zero_flag_set: assert property (
    rd && paddr == BBX_OFS_STATUS && zexp |-> prdata[BBX_ST_ZERO])
    else $error("zero flag not set");
  a_wreg_mask_zero: assert property (
    rd && paddr == BBX_OFS_WREG && wz |-> prdata == 32'h00000000)
    else $error("working register not zero");
  a_cycle_count: assert property (
    rd && paddr == BBX_OFS_CYCLES |-> prdata[15:0] == cnt)
    else $error("cycle count mismatch");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  c_skip_rise: cover property ($rose(skip_request));
  c_skip_fall: cover property ($fell(skip_request));
  c_slave_error: cover property (acc && pslverr);
endmodule

bind bbx_exec bbx_exec_assertions bbx_exec_assertions_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .skip_request(skip_request));

/* bench/byte_bit_instruction_exec_test.sv */
// Testbench: drives the executor over APB and checks register results.
// Assumes the register map and opcodes of bbx_pkg.
`timescale 1ns/1ps
module byte_bit_instruction_exec_test import bbx_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, skip_request;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  int n_errors, comparisons, n_instr;
  bbx_exec bbx_exec_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .skip_request(skip_request));
  always #2.5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t: no pready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic ins(input logic [13:0] w);
    n_instr++;
    wr(BBX_OFS_INSTR, {18'h0, w});
  endtask
  function automatic logic [13:0] fb(input logic [3:0] s, input logic d,
      input logic [6:0] f);
    return {BBX_CLS_BYTE, s, d, f};
  endfunction
  function automatic logic [13:0] bo(input logic [1:0] s,
      input logic [2:0] b, input logic [6:0] f);
    return {BBX_CLS_BIT, s, b, f};
  endfunction
  function automatic logic [13:0] ls(input logic [7:0] k);
    return {BBX_CLS_LIT, BBX_SUB_LSUM, 1'b0, k};
  endfunction
  function automatic logic [13:0] lm(input logic [7:0] k);
    return {BBX_CLS_LIT, BBX_SUB_LMASK, k};
  endfunction
  task automatic t_reset;
    rc(BBX_OFS_WREG, 32'h0);
    rc(BBX_OFS_STATUS, 32'h0);
    rc(BBX_OFS_CYCLES, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("t_reset done");
  endtask
  task automatic t_lsum;
    wr(BBX_OFS_WREG, 32'h8F);
    ins(ls(8'h71));
    rc(BBX_OFS_WREG, 32'h00);
    rc(BBX_OFS_STATUS, 32'h07);
    ins(ls(8'hFF));
    rc(BBX_OFS_WREG, 32'hFF);
    rc(BBX_OFS_STATUS, 32'h00);
    $display("t_lsum done");
  endtask
  task automatic t_fsum;
    wr(BBX_OFS_FADDR, 32'h7F);
    wr(BBX_OFS_FDATA, 32'h18);
    wr(BBX_OFS_WREG, 32'h28);
    ins(fb(BBX_SUB_FSUM, 1'b1, 7'h7F));
    rc(BBX_OFS_FDATA, 32'h40);
    rc(BBX_OFS_WREG, 32'h28);
    rc(BBX_OFS_STATUS, 32'h02);
    ins(fb(BBX_SUB_FSUM, 1'b0, 7'h7F));
    rc(BBX_OFS_WREG, 32'h68);
    rc(BBX_OFS_FDATA, 32'h40);
    rc(BBX_OFS_STATUS, 32'h00);
    $display("t_fsum done");
  endtask
  task automatic t_mask;
    wr(BBX_OFS_STATUS, 32'h01);
    wr(BBX_OFS_WREG, 32'hF0);
    wr(BBX_OFS_FADDR, 32'h05);
    wr(BBX_OFS_FDATA, 32'h0F);
    ins(fb(BBX_SUB_FMASK, 1'b1, 7'h05));
    rc(BBX_OFS_FDATA, 32'h00);
    rc(BBX_OFS_STATUS, 32'h05);
    ins(lm(8'h3C));
    rc(BBX_OFS_WREG, 32'h30);
    rc(BBX_OFS_STATUS, 32'h01);
    ins(lm(8'h00));
    ins(bo(BBX_SUB_BSET, 3'h3, 7'h05));
    rc(BBX_OFS_WREG, 32'h00);
    rc(BBX_OFS_FDATA, 32'h08);
    rc(BBX_OFS_STATUS, 32'h05);
    $display("t_mask done");
  endtask
  task automatic t_bits;
    wr(BBX_OFS_STATUS, 32'h03);
    wr(BBX_OFS_FADDR, 32'h10);
    wr(BBX_OFS_FDATA, 32'hA5);
    ins(bo(BBX_SUB_BCLR, 3'h0, 7'h10));
    ins(bo(BBX_SUB_BSET, 3'h6, 7'h10));
    rc(BBX_OFS_FDATA, 32'hE4);
    rc(BBX_OFS_STATUS, 32'h03);
    ins(fb(BBX_SUB_FCLR, 1'b1, 7'h10));
    rc(BBX_OFS_FDATA, 32'h00);
    rc(BBX_OFS_STATUS, 32'h07);
    $display("t_bits done");
  endtask
  task automatic t_skip;
    wr(BBX_OFS_FADDR, 32'h20);
    wr(BBX_OFS_FDATA, 32'h04);
    wr(BBX_OFS_WREG, 32'h10);
    wr(BBX_OFS_STATUS, 32'h00);
    ins(bo(BBX_SUB_SKZ, 3'h2, 7'h20));
    ins(ls(8'h01));
    rc(BBX_OFS_WREG, 32'h11);
    ins(bo(BBX_SUB_SKZ, 3'h0, 7'h20));
    rc(BBX_OFS_STATUS, 32'h08);
    chk({31'h0, skip_request}, 32'h1);
    ins(ls(8'h01));
    rc(BBX_OFS_WREG, 32'h11);
    rc(BBX_OFS_STATUS, 32'h00);
    ins(bo(BBX_SUB_SKO, 3'h2, 7'h20));
    @(posedge pclk);
    chk({31'h0, skip_request}, 32'h1);
    ins(lm(8'h00));
    ins(bo(BBX_SUB_SKO, 3'h7, 7'h20));
    ins(ls(8'h01));
    rc(BBX_OFS_WREG, 32'h12);
    rc(BBX_OFS_CYCLES, n_instr);
    $display("t_skip done");
  endtask
  task automatic t_odd;
    wr(BBX_OFS_STATUS, 32'h00);
    ins(14'h2000);
    rc(BBX_OFS_STATUS, 32'h10);
    wr(BBX_OFS_STATUS, 32'h10);
    rc(BBX_OFS_STATUS, 32'h00);
    apb(1'b1, 8'h44, 32'h5A);
    chk({31'h0, e}, 32'h1);
    wr(BBX_OFS_WREG, 32'h5A);
    ins(14'h0000);
    rc(BBX_OFS_WREG, 32'h5A);
    rc(BBX_OFS_STATUS, 32'h00);
    rc(BBX_OFS_CYCLES, n_instr);
    $display("t_odd done");
  endtask
  task automatic t_rst_mid;
    ins(bo(BBX_SUB_SKZ, 3'h0, 7'h20));
    @(posedge pclk);
    chk({31'h0, skip_request}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, skip_request}, 32'h0);
    presetn <= 1'b1;
    n_instr = 0;
    @(posedge pclk);
    rc(BBX_OFS_STATUS, 32'h00);
    rc(BBX_OFS_CYCLES, 32'h00);
    wr(BBX_OFS_WREG, 32'h10);
    ins(ls(8'h01));
    rc(BBX_OFS_WREG, 32'h11);
    rc(BBX_OFS_CYCLES, n_instr);
    $display("t_rst_mid done");
  endtask
  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    final_report;
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_lsum;
    t_fsum;
    t_mask;
    t_bits;
    t_skip;
    t_odd;
    t_rst_mid;
    final_report;
  end
endmodule
